//--- rtl/regulator_setting_pkg.sv
// Package with register map, field layout, defaults and voltage-code constants for the regulator settings.
// Notes on behaviour
// R01 - Converter hold pin low, button released: converter stays on only if hold-keep set.
// R02 - A disabled converter has its output discharged only when its discharge bit is set.
// R03 - Code 0-31 is 0.800 V+25 mV steps, 32-60 1.600 V+50 mV, 61-63 3.1-3.3 V.
// R04 - On divider variants the code is stored and read back but steers nothing.
// R05 - Host raises the code by at most 8 percent per single write.
// R06 - Host may lower the code by any amount in one write.
// R07 - Regulator hold pin low, button released: regulator stays on only if hold-keep set.
// R08 - A disabled regulator has its output discharged only when its discharge bit is set.
// R09 - Regulator code uses the converter mapping, only on variants without a divider.
// R10 - Mode bit 0 selects automatic PWM/PFM, 1 selects forced fixed-frequency PWM.
// R11 - Converter status bit reads 1 when below target or disabled, else 0.
// R12 - Regulator status bit reads 1 when below target or disabled, else 0.
// R13 - Writable fields reload defaults on lockout or reset; unused mode bits read zero.
// R14 - Status bits show live comparator levels; writes to them do nothing.
package regulator_setting_pkg;
    localparam logic [7:0] buck_setting_addr = 8'h07;
    localparam logic [7:0] linreg_setting_addr = 8'h08;
    localparam logic [7:0] mode_status_addr = 8'h09;
    localparam int hold_keep_bit = 7;
    localparam int discharge_bit = 6;
    localparam int force_pwm_bit = 7;
    localparam int buck_status_bit = 6;
    localparam int linreg_status_bit = 5;
    localparam int code_msb = 5;
    localparam logic [7:0] mode_writable_mask = 8'h80;
    // Defaults per variant; the default parameters select the first column of each table.
    localparam logic [7:0] buck_default_divider = 8'h29;
    localparam logic [7:0] buck_default_fixed_a = 8'h25;
    localparam logic [7:0] buck_default_fixed_b = 8'h26;
    localparam logic [7:0] linreg_default_main = 8'h65;
    localparam logic [7:0] linreg_default_alt = 8'h79;
    localparam logic [7:0] mode_default = 8'h00;
    localparam logic [5:0] fine_last_code = 6'h1f;
    localparam logic [5:0] coarse_last_code = 6'h3c;
    localparam logic [11:0] fine_base_mv = 12'h0320;
    localparam logic [11:0] fine_step_mv = 12'h0019;
    localparam logic [11:0] coarse_base_mv = 12'h0640;
    localparam logic [11:0] coarse_step_mv = 12'h0032;
    localparam logic [11:0] top_base_mv = 12'h0c1c;
    localparam logic [11:0] top_step_mv = 12'h0064;
    localparam logic [5:0] top_first_code = 6'h3d;
endpackage : regulator_setting_pkg

//--- rtl/regulator_setting_register_bank.sv
// Register bank for converter and linear-regulator settings, mode and live power-good status.
`timescale 1ns/1ns
module regulator_setting_register_bank #(
    parameter logic [7:0] buck_default = regulator_setting_pkg::buck_default_divider,
    parameter logic [7:0] linreg_default = regulator_setting_pkg::linreg_default_main,
    parameter bit buck_has_divider = 1'b1,
    parameter bit linreg_has_divider = 1'b0
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic undervoltage_or_reset_load,
    input wire logic wr_en,
    input wire logic [7:0] addr,
    input wire logic [7:0] wr_data,
    output logic [7:0] rd_data,
    input wire logic buck_hold_pin,
    input wire logic linreg_hold_pin,
    input wire logic pushbutton_input_n,
    input wire logic buck_power_good_raw,
    input wire logic linreg_power_good_raw,
    output logic buck_enable,
    output logic buck_discharge,
    output logic buck_force_pwm,
    output logic buck_code_valid,
    output logic [11:0] buck_target_mv,
    output logic linreg_enable,
    output logic linreg_discharge,
    output logic linreg_code_valid,
    output logic [11:0] linreg_target_mv
);
    logic [7:0] buck_q;
    logic [7:0] linreg_q;
    logic mode_q;
    logic [1:0] buck_hold_s;
    logic [1:0] linreg_hold_s;
    logic [1:0] button_s;
    logic [1:0] buck_pg_s;
    logic [1:0] linreg_pg_s;
    logic buck_enable_q;
    logic linreg_enable_q;
    logic buck_discharge_q;
    logic linreg_discharge_q;
    logic [11:0] buck_mv_q;
    logic [11:0] linreg_mv_q;
    logic [7:0] rd_data_q;

    // Pins and comparator outputs are asynchronous to the core clock.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            buck_hold_s <= 2'h0;
            linreg_hold_s <= 2'h0;
            button_s <= 2'h3;
            buck_pg_s <= 2'h0;
            linreg_pg_s <= 2'h0;
        end else begin
            buck_hold_s <= {buck_hold_s[0], buck_hold_pin};
            linreg_hold_s <= {linreg_hold_s[0], linreg_hold_pin};
            button_s <= {button_s[0], pushbutton_input_n};
            buck_pg_s <= {buck_pg_s[0], buck_power_good_raw};
            linreg_pg_s <= {linreg_pg_s[0], linreg_power_good_raw};
        end
    end

    wire logic buck_sel = (addr == regulator_setting_pkg::buck_setting_addr);
    wire logic linreg_sel = (addr == regulator_setting_pkg::linreg_setting_addr);
    wire logic mode_sel = (addr == regulator_setting_pkg::mode_status_addr);
    wire logic button_pressed = !button_s[1];

    // A held pin or a pressed button keeps a supply on; otherwise the hold-keep bit decides.
    wire logic buck_on_d = buck_hold_s[1] || button_pressed
        || buck_q[regulator_setting_pkg::hold_keep_bit]; // R01
    wire logic linreg_on_d = linreg_hold_s[1] || button_pressed
        || linreg_q[regulator_setting_pkg::hold_keep_bit]; // R07
    wire logic buck_dis_d = !buck_on_d
        && buck_q[regulator_setting_pkg::discharge_bit]; // R02
    wire logic linreg_dis_d = !linreg_on_d
        && linreg_q[regulator_setting_pkg::discharge_bit]; // R08

    // Status bits are active-high "not in regulation", taken live from the comparators.
    wire logic buck_nir = !buck_pg_s[1] || !buck_enable_q; // R11
    wire logic linreg_nir = !linreg_pg_s[1] || !linreg_enable_q; // R12

    wire logic [7:0] mode_rd = {mode_q, buck_nir, linreg_nir, 5'h00}; // R13 R14
    wire logic [7:0] rd_mux = buck_sel ? buck_q :
        linreg_sel ? linreg_q : mode_sel ? mode_rd : 8'h00;

    wire logic [11:0] buck_dec_mv;
    wire logic [11:0] linreg_dec_mv;

    voltage_code_decoder buck_decode (
        .code(buck_q[regulator_setting_pkg::code_msb:0]),
        .target_mv(buck_dec_mv)
    );

    voltage_code_decoder linreg_decode (
        .code(linreg_q[regulator_setting_pkg::code_msb:0]),
        .target_mv(linreg_dec_mv)
    );

    // Defaults load on reset and on the lockout strobe; the strobe outranks a write.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            buck_q <= buck_default; // R13
            linreg_q <= linreg_default;
            mode_q <= regulator_setting_pkg::mode_default[regulator_setting_pkg::force_pwm_bit];
        end else if (undervoltage_or_reset_load) begin
            buck_q <= buck_default; // R13
            linreg_q <= linreg_default;
            mode_q <= regulator_setting_pkg::mode_default[regulator_setting_pkg::force_pwm_bit];
        end else if (wr_en) begin
            if (buck_sel) begin
                buck_q <= wr_data;
            end
            if (linreg_sel) begin
                linreg_q <= wr_data;
            end
            if (mode_sel) begin
                mode_q <= wr_data[regulator_setting_pkg::force_pwm_bit]; // R10 R14
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            buck_enable_q <= 1'b0;
            linreg_enable_q <= 1'b0;
            buck_discharge_q <= 1'b0;
            linreg_discharge_q <= 1'b0;
            buck_mv_q <= 12'h000;
            linreg_mv_q <= 12'h000;
            rd_data_q <= 8'h00;
        end else begin
            buck_enable_q <= buck_on_d;
            linreg_enable_q <= linreg_on_d;
            buck_discharge_q <= buck_dis_d;
            linreg_discharge_q <= linreg_dis_d;
            buck_mv_q <= buck_has_divider ? 12'h000 : buck_dec_mv; // R04
            linreg_mv_q <= linreg_has_divider ? 12'h000 : linreg_dec_mv; // R09
            rd_data_q <= rd_mux;
        end
    end

    assign buck_enable = buck_enable_q;
    assign linreg_enable = linreg_enable_q;
    assign buck_discharge = buck_discharge_q;
    assign linreg_discharge = linreg_discharge_q;
    assign buck_force_pwm = mode_q; // R10
    assign buck_target_mv = buck_mv_q;
    assign linreg_target_mv = linreg_mv_q;
    // A divider variant ignores the code, so the target is flagged as not meaningful.
    assign buck_code_valid = !buck_has_divider; // R04
    assign linreg_code_valid = !linreg_has_divider; // R09
    assign rd_data = rd_data_q;

    // Code increases larger than 8 percent are the host's duty to avoid, so no check here.

    AST_BUCK_HOLD: assert property (@(posedge core_clk) disable iff (!rst_b) // R01
        (!buck_hold_s[1] && !button_pressed && !buck_q[regulator_setting_pkg::hold_keep_bit])
        |=> !buck_enable)
        else $error("converter stayed on without hold");
    AST_LINREG_HOLD: assert property (@(posedge core_clk) disable iff (!rst_b) // R07
        (linreg_q[regulator_setting_pkg::hold_keep_bit] || linreg_hold_s[1]) |=> linreg_enable)
        else $error("regulator dropped while held");
    AST_BUCK_DISCH: assert property (@(posedge core_clk) disable iff (!rst_b) // R02
        buck_discharge
        |-> (!buck_enable && $past(buck_q[regulator_setting_pkg::discharge_bit])))
        else $error("converter discharge without cause");
    AST_LINREG_DISCH: assert property (@(posedge core_clk) disable iff (!rst_b) // R08
        linreg_discharge
        |-> (!linreg_enable && $past(linreg_q[regulator_setting_pkg::discharge_bit])))
        else $error("regulator discharge without cause");
    AST_MODE_WRITE: assert property (@(posedge core_clk) disable iff (!rst_b) // R10
        (wr_en && mode_sel && !undervoltage_or_reset_load) |=>
        buck_force_pwm == $past(wr_data[regulator_setting_pkg::force_pwm_bit]))
        else $error("mode bit not written");
    AST_STATUS_READ: assert property (@(posedge core_clk) disable iff (!rst_b) // R11 R13
        mode_sel |=> (rd_data[regulator_setting_pkg::buck_status_bit] == $past(buck_nir)
        && rd_data[regulator_setting_pkg::linreg_status_bit - 1:0] == 5'h00))
        else $error("mode register read wrong");
    AST_LINREG_STATUS: assert property (@(posedge core_clk) disable iff (!rst_b) // R12
        (mode_sel && !linreg_enable) |=> rd_data[regulator_setting_pkg::linreg_status_bit])
        else $error("disabled regulator reads in regulation");
    AST_DEFAULT_LOAD: assert property (@(posedge core_clk) disable iff (!rst_b) // R13
        undervoltage_or_reset_load |=> (buck_q == buck_default && linreg_q == linreg_default
        && !mode_q))
        else $error("defaults not loaded");
    AST_CODE_MAP: assert property (@(posedge core_clk) disable iff (!rst_b) // R03
        (!buck_has_divider && buck_q[regulator_setting_pkg::code_msb:0] == 6'h3f)
        |=> buck_target_mv == 12'hce4)
        else $error("top code not 3.3 V");

    // Pins and comparators are watched raw, so each sequence waits out both synchroniser
    // stages before a reaction is expected; a shorter wait would flag a correct design.
    sequence buck_pin_seen;
        buck_hold_pin [*3];
    endsequence

    sequence linreg_pin_seen;
        linreg_hold_pin [*3];
    endsequence

    sequence button_seen;
        !pushbutton_input_n [*3];
    endsequence

    sequence buck_pg_lost;
        !buck_power_good_raw [*2];
    endsequence

    sequence linreg_pg_lost;
        !linreg_power_good_raw [*2];
    endsequence

    sequence buck_pg_held;
        buck_power_good_raw [*2];
    endsequence

    sequence linreg_pg_held;
        linreg_power_good_raw [*2];
    endsequence

    property linreg_code_gives(logic [5:0] c, logic [11:0] mv);
        @(posedge core_clk) disable iff (!rst_b)
        (!linreg_has_divider && linreg_q[regulator_setting_pkg::code_msb:0] == c)
        |=> linreg_target_mv == mv;
    endproperty

    AST_BUCK_PIN_KEEP: assert property (@(posedge core_clk) disable iff (!rst_b) // R01
        buck_pin_seen |=> buck_enable)
        else $error("converter off while its hold pin is high");
    AST_LINREG_PIN_KEEP: assert property (@(posedge core_clk) disable iff (!rst_b) // R07
        linreg_pin_seen |=> linreg_enable)
        else $error("regulator off while its hold pin is high");
    AST_BUTTON_KEEP: assert property (@(posedge core_clk) disable iff (!rst_b) // R01 R07
        button_seen |=> (buck_enable && linreg_enable))
        else $error("supply off while the button is pressed");
    AST_BUCK_BIT_KEEP: assert property (@(posedge core_clk) disable iff (!rst_b) // R01
        buck_q[regulator_setting_pkg::hold_keep_bit] |=> buck_enable)
        else $error("converter off although hold-keep is set");
    AST_LINREG_BIT_DROP: assert property (@(posedge core_clk) disable iff (!rst_b) // R07
        (!linreg_hold_s[1] && !button_pressed
        && !linreg_q[regulator_setting_pkg::hold_keep_bit]) |=> !linreg_enable)
        else $error("regulator on without any hold");

    AST_BUCK_DISCH_SET: assert property (@(posedge core_clk) disable iff (!rst_b) // R02
        (!buck_hold_s[1] && !button_pressed && !buck_q[regulator_setting_pkg::hold_keep_bit]
        && buck_q[regulator_setting_pkg::discharge_bit]) |=> buck_discharge)
        else $error("disabled converter not discharged");
    AST_BUCK_DISCH_OFF: assert property (@(posedge core_clk) disable iff (!rst_b) // R02
        !buck_q[regulator_setting_pkg::discharge_bit] |=> !buck_discharge)
        else $error("converter discharged with the bit clear");
    AST_LINREG_DISCH_SET: assert property (@(posedge core_clk) disable iff (!rst_b) // R08
        (!linreg_hold_s[1] && !button_pressed
        && !linreg_q[regulator_setting_pkg::hold_keep_bit]
        && linreg_q[regulator_setting_pkg::discharge_bit]) |=> linreg_discharge)
        else $error("disabled regulator not discharged");
    AST_LINREG_DISCH_OFF: assert property (@(posedge core_clk) disable iff (!rst_b) // R08
        !linreg_q[regulator_setting_pkg::discharge_bit] |=> !linreg_discharge)
        else $error("regulator discharged with the bit clear");

    AST_BUCK_WRITE: assert property (@(posedge core_clk) disable iff (!rst_b) // R04
        (wr_en && buck_sel && !undervoltage_or_reset_load)
        |=> buck_q == $past(wr_data))
        else $error("converter setting not stored");
    AST_LINREG_WRITE: assert property (@(posedge core_clk) disable iff (!rst_b) // R09
        (wr_en && linreg_sel && !undervoltage_or_reset_load)
        |=> linreg_q == $past(wr_data))
        else $error("regulator setting not stored");
    AST_BUCK_READ: assert property (@(posedge core_clk) disable iff (!rst_b) // R04
        buck_sel |=> rd_data == $past(buck_q))
        else $error("converter setting read back wrong");
    AST_LINREG_READ: assert property (@(posedge core_clk) disable iff (!rst_b) // R09
        linreg_sel |=> rd_data == $past(linreg_q))
        else $error("regulator setting read back wrong");
    AST_UNMAPPED_READ: assert property (@(posedge core_clk) disable iff (!rst_b) // R13
        (!buck_sel && !linreg_sel && !mode_sel) |=> rd_data == 8'h00)
        else $error("unmapped address reads nonzero");
    AST_MODE_KEEP: assert property (@(posedge core_clk) disable iff (!rst_b) // R10 R14
        (!(wr_en && mode_sel) && !undervoltage_or_reset_load)
        |=> $stable(buck_force_pwm))
        else $error("mode bit changed without a write");
    AST_LOAD_OUTRANKS: assert property (@(posedge core_clk) disable iff (!rst_b) // R13
        (undervoltage_or_reset_load && wr_en)
        |=> (buck_q == buck_default && linreg_q == linreg_default))
        else $error("write won over the default load");

    AST_BUCK_PG_LOST: assert property (@(posedge core_clk) disable iff (!rst_b) // R11
        (buck_pg_lost ##1 mode_sel) |=> rd_data[regulator_setting_pkg::buck_status_bit])
        else $error("converter reads in regulation after power-good loss");
    AST_LINREG_PG_LOST: assert property (@(posedge core_clk) disable iff (!rst_b) // R12
        (linreg_pg_lost ##1 mode_sel) |=> rd_data[regulator_setting_pkg::linreg_status_bit])
        else $error("regulator reads in regulation after power-good loss");
    AST_BUCK_PG_GOOD: assert property (@(posedge core_clk) disable iff (!rst_b) // R11
        (buck_pg_held ##1 (mode_sel && buck_enable))
        |=> !rd_data[regulator_setting_pkg::buck_status_bit])
        else $error("converter in range reads out of regulation");
    AST_LINREG_PG_GOOD: assert property (@(posedge core_clk) disable iff (!rst_b) // R12
        (linreg_pg_held ##1 (mode_sel && linreg_enable))
        |=> !rd_data[regulator_setting_pkg::linreg_status_bit])
        else $error("regulator in range reads out of regulation");
    AST_BUCK_STATUS_OFF: assert property (@(posedge core_clk) disable iff (!rst_b) // R11
        (mode_sel && !buck_enable) |=> rd_data[regulator_setting_pkg::buck_status_bit])
        else $error("disabled converter reads in regulation");
    AST_BUCK_DIVIDER: assert property (@(posedge core_clk) disable iff (!rst_b) // R04
        (buck_has_divider && wr_en && buck_sel) |=> ##1 buck_target_mv == 12'h000)
        else $error("divider variant steered by its code");

    AST_LINREG_CODE_FIRST: assert property (linreg_code_gives(6'h00, 12'h320)) // R03 R09
        else $error("code 0 not 0.800 V");
    AST_LINREG_CODE_FINE_END: assert property (linreg_code_gives(6'h1f, 12'h627)) // R03 R09
        else $error("code 31 not 1.575 V");
    AST_LINREG_CODE_COARSE: assert property (linreg_code_gives(6'h20, 12'h640)) // R03 R09
        else $error("code 32 not 1.600 V");
    AST_LINREG_CODE_COARSE_END: assert property (linreg_code_gives(6'h3c, 12'hbb8)) // R03 R09
        else $error("code 60 not 3.000 V");
    AST_LINREG_CODE_TOP: assert property (linreg_code_gives(6'h3d, 12'hc1c)) // R03 R09
        else $error("code 61 not 3.1 V");
    AST_LINREG_CODE_LAST: assert property (linreg_code_gives(6'h3f, 12'hce4)) // R03 R09
        else $error("code 63 not 3.3 V");
endmodule : regulator_setting_register_bank

//--- rtl/voltage_code_decoder.sv
// Converts a 6-bit output-voltage code into a target voltage in millivolts.
`timescale 1ns/1ns
module voltage_code_decoder (
    input wire logic [5:0] code,
    output logic [11:0] target_mv
);
    wire logic [11:0] code_w = {6'h00, code};
    wire logic [11:0] fine_mv = 12'(regulator_setting_pkg::fine_base_mv
        + code_w * regulator_setting_pkg::fine_step_mv);
    wire logic [11:0] coarse_mv = 12'(regulator_setting_pkg::coarse_base_mv
        + (code_w - 12'h0020) * regulator_setting_pkg::coarse_step_mv);
    wire logic [11:0] top_mv = 12'(regulator_setting_pkg::top_base_mv
        + (code_w - {6'h00, regulator_setting_pkg::top_first_code})
        * regulator_setting_pkg::top_step_mv);
    // R03
    assign target_mv = (code <= regulator_setting_pkg::fine_last_code) ? fine_mv :
        (code <= regulator_setting_pkg::coarse_last_code) ? coarse_mv : top_mv;
endmodule : voltage_code_decoder

//--- tb/regulator_partner.sv
// Model of the regulator circuits that drive the power-good comparator levels.
`timescale 1ns/1ns
module regulator_partner #(
    parameter int settle = 3
) (
    input wire logic core_clk,
    input wire logic buck_enable,
    input wire logic linreg_enable,
    input wire logic buck_fault,
    input wire logic linreg_fault,
    output logic buck_power_good_raw,
    output logic linreg_power_good_raw
);
    // Outputs ramp slowly, so power-good rises some cycles after enable but drops at once.
    logic [7:0] buck_sr = '0;
    logic [7:0] lin_sr = '0;
    always @(posedge core_clk) begin
        buck_sr <= {buck_sr[6:0], buck_enable & ~buck_fault};
        lin_sr <= {lin_sr[6:0], linreg_enable & ~linreg_fault};
    end
    assign buck_power_good_raw = buck_sr[settle - 1] & buck_enable & ~buck_fault;
    assign linreg_power_good_raw = lin_sr[settle - 1] & linreg_enable & ~linreg_fault;
endmodule : regulator_partner

//--- tb/testbench.sv
// Self-checking bench for the regulator setting register bank.
`timescale 1ns/1ns
`define CHK(g, e) check_val(16'(g), 16'(e));
module testbench;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic undervoltage_or_reset_load = 1'b0;
    logic wr_en = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wr_data = 8'h00;
    logic buck_hold_pin = 1'b0;
    logic linreg_hold_pin = 1'b0;
    logic pushbutton_input_n = 1'b1;
    logic buck_fault = 1'b0;
    logic linreg_fault = 1'b0;
    logic [7:0] rd_data;
    logic buck_power_good_raw, linreg_power_good_raw, buck_enable, buck_discharge;
    logic buck_force_pwm, buck_code_valid, linreg_enable, linreg_discharge, linreg_code_valid;
    logic [11:0] buck_target_mv, linreg_target_mv;
    int n_fail = 0;
    int samples_checked = 0;
    int cycles = 0;
    regulator_setting_register_bank dut_u (.core_clk, .rst_b, .undervoltage_or_reset_load,
        .wr_en, .addr, .wr_data, .rd_data, .buck_hold_pin, .linreg_hold_pin,
        .pushbutton_input_n, .buck_power_good_raw, .linreg_power_good_raw, .buck_enable,
        .buck_discharge, .buck_force_pwm, .buck_code_valid, .buck_target_mv, .linreg_enable,
        .linreg_discharge, .linreg_code_valid, .linreg_target_mv);
    regulator_partner partner_u (.core_clk, .buck_enable, .linreg_enable, .buck_fault,
        .linreg_fault, .buck_power_good_raw, .linreg_power_good_raw);
    always #25 core_clk = ~core_clk;
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : print_verdict
    // A hang would otherwise run forever; the whole sequence needs well under a thousand cycles.
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            print_verdict();
        end
    end
    task automatic check_val(input logic [15:0] g, input logic [15:0] e);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : check_val
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask : cyc
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wr_data = d;
        wr_en = 1'b1;
        cyc(1);
        wr_en = 1'b0;
        cyc(2);
    endtask : wr
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        addr = a;
        cyc(2);
        `CHK(rd_data, e)
    endtask : rdchk
    function automatic logic [11:0] mv(input int c);
        if (c < 32) return 12'h320 + 12'(c) * 12'h019;
        if (c < 61) return 12'h640 + 12'(c - 32) * 12'h032;
        return 12'hc1c + 12'(c - 61) * 12'h064;
    endfunction : mv
    task automatic t_reset();
        rdchk(8'h07, 8'h29);
        rdchk(8'h08, 8'h65);
        rdchk(8'h09, 8'h60);
        `CHK({buck_code_valid, linreg_code_valid, buck_target_mv}, 14'h1000)
        $display("test reset done");
    endtask : t_reset
    task automatic t_hold();
        for (int i = 0; i < 2; i++) begin
            wr(8'h07 + 8'(i), 8'h40);
            `CHK(i ? {linreg_enable, linreg_discharge} : {buck_enable, buck_discharge}, 1)
            wr(8'h07 + 8'(i), 8'h80);
            `CHK(i ? {linreg_enable, linreg_discharge} : {buck_enable, buck_discharge}, 2)
            wr(8'h07 + 8'(i), 8'h00);
            `CHK(i ? {linreg_enable, linreg_discharge} : {buck_enable, buck_discharge}, 0)
        end
        buck_hold_pin = 1'b1;
        linreg_hold_pin = 1'b1;
        cyc(4);
        `CHK({buck_enable, linreg_enable}, 3)
        buck_hold_pin = 1'b0;
        linreg_hold_pin = 1'b0;
        pushbutton_input_n = 1'b0;
        cyc(4);
        `CHK({buck_enable, linreg_enable}, 3)
        pushbutton_input_n = 1'b1;
        cyc(4);
        `CHK({buck_enable, linreg_enable}, 0)
        $display("test hold done");
    endtask : t_hold
    task automatic t_codes();
        // Upward steps go one code at a time to stay inside the host step limit.
        for (int c = 0; c < 64; c++) begin
            wr(8'h08, 8'h80 | 8'(c));
            `CHK(linreg_target_mv, mv(c))
        end
        wr(8'h08, 8'h80);
        `CHK(linreg_target_mv, mv(0))
        wr(8'h07, 8'h81);
        rdchk(8'h07, 8'h81);
        `CHK(buck_target_mv, 0)
        $display("test codes done");
    endtask : t_codes
    task automatic t_mode();
        cyc(8);
        wr(8'h09, 8'hff);
        rdchk(8'h09, 8'h80);
        `CHK(buck_force_pwm, 1)
        buck_fault = 1'b1;
        cyc(6);
        rdchk(8'h09, 8'hc0);
        linreg_fault = 1'b1;
        cyc(6);
        rdchk(8'h09, 8'he0);
        buck_fault = 1'b0;
        linreg_fault = 1'b0;
        wr(8'h09, 8'h7f);
        cyc(6);
        rdchk(8'h09, 8'h00);
        `CHK(buck_force_pwm, 0)
        wr(8'h0a, 8'hff);
        rdchk(8'h0a, 8'h00);
        $display("test mode done");
    endtask : t_mode
    task automatic t_load();
        wr(8'h09, 8'h80);
        undervoltage_or_reset_load = 1'b1;
        wr(8'h07, 8'hff);
        undervoltage_or_reset_load = 1'b0;
        rdchk(8'h07, 8'h29);
        rdchk(8'h08, 8'h65);
        `CHK(buck_force_pwm, 0)
        // A reset in mid-run must bring a rewritten setting back to its default.
        wr(8'h08, 8'h00);
        rst_b = 1'b0;
        cyc(2);
        rst_b = 1'b1;
        cyc(1);
        rdchk(8'h08, 8'h65);
        $display("test load done");
    endtask : t_load
    initial begin
        cyc(10);
        rst_b = 1'b1;
        cyc(1);
        t_reset();
        t_hold();
        t_codes();
        t_mode();
        t_load();
        print_verdict();
    end
endmodule : testbench
